// ### common/dcc_pkg.sv
// Shared constants and types for the channel control block
package dcc_pkg;

  localparam int NUM_CH      = 4;
  localparam int NUM_EXT_CH  = 2;
  localparam int ADDR_W      = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CH0_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CH1_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CH2_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CH3_CTRL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_GLOBAL   = 8'h10;

  // Channel control field positions
  localparam int BIT_DE     = 0;
  localparam int BIT_TE     = 1;
  localparam int BIT_IE     = 2;
  localparam int BIT_TS     = 3;
  localparam int BIT_TM     = 4;
  localparam int BIT_DS     = 5;
  localparam int BIT_AL     = 6;
  localparam int BIT_AM     = 7;
  localparam int BIT_SRC_LO = 8;
  localparam int BIT_SRC_HI = 11;

  // Global operation field positions
  localparam int BIT_GEN    = 0;
  localparam int BIT_NMI_ABORT_FLAG   = 1;
  localparam int BIT_AEF    = 2;
  localparam int BIT_PRI_LO = 8;
  localparam int BIT_PRI_HI = 9;

  // Reset values and write masks
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] GLOBAL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK_EXT = 16'hfffd;
  localparam logic [15:0] CTRL_WMASK_INT = 16'hff1d;
  localparam logic [15:0] GLOBAL_WMASK   = 16'h0301;

  // Request source codes
  localparam logic [3:0] SRC_EXT_DUAL    = 4'h0;
  localparam logic [3:0] SRC_EXT_MEM2DEV = 4'h2;
  localparam logic [3:0] SRC_EXT_DEV2MEM = 4'h3;
  localparam logic [3:0] SRC_AUTO        = 4'hc;

  // Decoded mode of one channel for the bus sequencer
  typedef struct packed {
    logic single_addr;
    logic mem_to_dev;
    logic burst;
    logic word_size;
    logic auto_req;
  } dcc_mode_t;

endpackage

// ### src/dcc_channel_ctrl.sv
// Per-channel DMA request, acknowledge and completion control with APB registers
`timescale 1ns/1ns

// Overview of operation
// R1: Code 0000 external dual; 0010 memory to device; 0011 device to memory.
// R2: Codes 0100-0111 select serial 0/1 receive-full and transmit-empty requests.
// R3: Codes 1000-1011 select timer 0-3 match A requests.
// R4: Code 1100 auto-request, 1101 converter done; 0001, 1110, 1111 reserved.
// R5: External request sources work only on channels 0 and 1.
// R6: Dual mode acknowledge in read cycle if phase 0, write cycle if 1.
// R7: Acknowledge polarity bit 0 active high, 1 active low.
// R8: Request pin detected by low level or, if selected, falling edge.
// R9: Bus mode bit selects cycle-steal (0) or burst (1).
// R10: Size bit selects byte (0) or 16-bit word (1) units.
// R11: Software picks byte size for byte-only peripherals.
// R12: Interrupt enable gates completion flag onto the done interrupt.
// R13: Completion flag sets when final unit completes normally.
// R14: Aborts by NMI, address error or enable clear leave flag clear.
// R15: Completion flag clears by writing 0 after reading 1; writing 1 ignored.
// R16: No transfers start while completion flag is set.
// R17: Auto-request runs once both enables set and all flags clear.
// R18: Other modes transfer on a selected request when enabled and flags clear.
// R19: Clearing channel enable stops the channel.
// R20: Reset or standby clears every control field.
// R21: Software changes request source only with channel enable clear.
// R22: Phase, polarity and detect bits writable only on channels 0 and 1.
// R23: Global enable needed for any transfer; clearing it aborts all.
// R24: NMI or address error flag keeps every channel disabled.
module dcc_channel_ctrl #(
  parameter int NCH  = dcc_pkg::NUM_CH,
  parameter int NEXT = dcc_pkg::NUM_EXT_CH
) (
  // Clock, reset, power
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  input  wire logic                           standby,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [dcc_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // External request and acknowledge pins
  input  wire logic [NEXT-1:0]                ext_request_pin_n,
  output logic      [NEXT-1:0]                ext_ack_pin,
  // On-chip peripheral requests
  input  wire logic                           serial0_rx_full_req,
  input  wire logic                           serial0_tx_empty_req,
  input  wire logic                           serial1_rx_full_req,
  input  wire logic                           serial1_tx_empty_req,
  input  wire logic [3:0]                     timer_match_req,
  input  wire logic                           conversion_done_req,
  // Bus sequencer side
  input  wire logic [NCH-1:0]                 unit_done,
  input  wire logic [NCH-1:0]                 last_unit,
  input  wire logic [NCH-1:0]                 read_cycle,
  input  wire logic [NCH-1:0]                 write_cycle,
  input  wire logic                           nmi_event,
  input  wire logic                           addr_error_event,
  output logic      [NCH-1:0]                 xfer_request,
  output logic      [NCH-1:0]                 ch_enabled,
  output dcc_pkg::dcc_mode_t [NCH-1:0]        ch_mode,
  // Interrupts toward the CPU
  output logic      [NCH-1:0]                 transfer_done_irq
);

  // Bus decode
  wire logic        setup_ph  = psel & ~penable;
  wire logic        access_ph = psel & penable;
  wire logic        wr_acc    = access_ph & pwrite & clk_en;
  wire logic        rd_acc    = access_ph & ~pwrite & clk_en;
  wire logic        hit_glb   = (paddr == dcc_pkg::OFF_GLOBAL);
  wire logic [NCH-1:0] hit_ch;
  wire logic        mapped    = hit_glb | (|hit_ch);

  logic [15:0]          glb_reg;
  logic [15:0]          glb_next;
  logic                 nmi_seen_reg;
  logic                 ae_seen_reg;
  logic [NCH-1:0][15:0] ctl_q;
  logic [31:0]          prdata_reg;
  logic [31:0]          rd_mux;

  wire logic gen_en   = glb_reg[dcc_pkg::BIT_GEN];
  wire logic nmi_flag = glb_reg[dcc_pkg::BIT_NMI_ABORT_FLAG];
  wire logic ae_flag  = glb_reg[dcc_pkg::BIT_AEF];
  // R23 R24 global gate
  wire logic glb_ok   = gen_en & ~nmi_flag & ~ae_flag;

  wire logic [7:0] periph_req = {timer_match_req, serial1_tx_empty_req,
                                 serial1_rx_full_req, serial0_tx_empty_req,
                                 serial0_rx_full_req};

  // Read data captured in setup so the access phase never waits
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_glb) begin
      rd_mux = {16'h0000, glb_reg};
    end
    for (int k = 0; k < NCH; k++) begin
      if (hit_ch[k]) begin
        rd_mux = {16'h0000, ctl_q[k]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en && setup_ph) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // Global operation register
  wire logic glb_wr = wr_acc & hit_glb;
  always_comb begin
    glb_next = glb_reg;
    if (glb_wr) begin
      glb_next = (glb_reg & ~dcc_pkg::GLOBAL_WMASK) | (pwdata[15:0] & dcc_pkg::GLOBAL_WMASK);
      if (nmi_seen_reg && !pwdata[dcc_pkg::BIT_NMI_ABORT_FLAG]) begin
        glb_next[dcc_pkg::BIT_NMI_ABORT_FLAG] = 1'b0;
      end
      if (ae_seen_reg && !pwdata[dcc_pkg::BIT_AEF]) begin
        glb_next[dcc_pkg::BIT_AEF] = 1'b0;
      end
    end
    // Event wins over a simultaneous clear
    if (nmi_event) begin
      glb_next[dcc_pkg::BIT_NMI_ABORT_FLAG] = 1'b1;
    end
    if (addr_error_event) begin
      glb_next[dcc_pkg::BIT_AEF] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_reg      <= dcc_pkg::GLOBAL_RESET;
      nmi_seen_reg <= 1'b0;
      ae_seen_reg  <= 1'b0;
    end else if (clk_en) begin
      if (standby) begin
        glb_reg      <= dcc_pkg::GLOBAL_RESET;
        nmi_seen_reg <= 1'b0;
        ae_seen_reg  <= 1'b0;
      end else begin
        glb_reg <= glb_next;
        if (glb_wr) begin
          nmi_seen_reg <= 1'b0;
          ae_seen_reg  <= 1'b0;
        end else if (rd_acc && hit_glb) begin
          nmi_seen_reg <= nmi_seen_reg | nmi_flag;
          ae_seen_reg  <= ae_seen_reg | ae_flag;
        end
      end
    end
  end

  // Per-channel control
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam bit HAS_EXT = (i < NEXT);
    localparam logic [15:0] WMASK = HAS_EXT ? dcc_pkg::CTRL_WMASK_EXT
                                            : dcc_pkg::CTRL_WMASK_INT;

    logic [15:0] ctl_reg;
    logic [15:0] ctl_next;
    logic        te_seen_reg;
    logic        pin_q_reg;
    logic        edge_pend_reg;
    logic        ack_reg;

    assign hit_ch[i] = (paddr == dcc_pkg::ADDR_W'(4 * i));
    assign ctl_q[i]  = ctl_reg;

    wire logic       wr_hit = wr_acc & hit_ch[i];
    wire logic [3:0] src    = ctl_reg[dcc_pkg::BIT_SRC_HI:dcc_pkg::BIT_SRC_LO];
    wire logic       te     = ctl_reg[dcc_pkg::BIT_TE];

    // R16 R17 R18 R19 enable gating
    wire logic en = ctl_reg[dcc_pkg::BIT_DE] & ~te & glb_ok;
    assign ch_enabled[i] = en;

    // R13 R14 normal end only while enabled
    wire logic te_set = unit_done[i] & last_unit[i] & en;

    always_comb begin
      ctl_next = ctl_reg;
      if (wr_hit) begin
        // R22 masked writes
        ctl_next = (ctl_reg & ~WMASK) | (pwdata[15:0] & WMASK);
        // R15 clear only after reading 1
        if (te_seen_reg && !pwdata[dcc_pkg::BIT_TE]) begin
          ctl_next[dcc_pkg::BIT_TE] = 1'b0;
        end
      end
      if (te_set) begin
        ctl_next[dcc_pkg::BIT_TE] = 1'b1;
      end
    end

    // R8 falling edge or low level detect
    wire logic pin_n    = HAS_EXT ? ext_request_pin_n[i % NEXT] : 1'b1;
    wire logic fall     = pin_q_reg & ~pin_n;
    wire logic ext_det  = ctl_reg[dcc_pkg::BIT_DS] ? edge_pend_reg : ~pin_n;
    // R5 no external source past channel 1
    wire logic ext_req  = HAS_EXT & ext_det;

    // R1 R2 R3 R4 source selection, reserved codes request nothing
    wire logic [15:0] src_vec = {1'b0, 1'b0, conversion_done_req, 1'b1,
                                 periph_req, ext_req, ext_req, 1'b0, ext_req};
    assign xfer_request[i] = en & src_vec[src];

    // R9 R10 mode decode for sequencer
    wire logic single = HAS_EXT & ((src == dcc_pkg::SRC_EXT_MEM2DEV) |
                                   (src == dcc_pkg::SRC_EXT_DEV2MEM));
    assign ch_mode[i].single_addr = single;
    assign ch_mode[i].mem_to_dev  = single & (src == dcc_pkg::SRC_EXT_MEM2DEV);
    assign ch_mode[i].burst       = ctl_reg[dcc_pkg::BIT_TM];
    assign ch_mode[i].word_size   = ctl_reg[dcc_pkg::BIT_TS];
    assign ch_mode[i].auto_req    = (src == dcc_pkg::SRC_AUTO);

    // R12 interrupt follows flag and enable
    assign transfer_done_irq[i] = te & ctl_reg[dcc_pkg::BIT_IE];

    // R6 phase choice, ignored in single mode
    wire logic ack_act = single ? (read_cycle[i] | write_cycle[i])
                                : (ctl_reg[dcc_pkg::BIT_AM] ? write_cycle[i] : read_cycle[i]);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_reg       <= dcc_pkg::CTRL_RESET;
        te_seen_reg   <= 1'b0;
        pin_q_reg     <= 1'b1;
        edge_pend_reg <= 1'b0;
        ack_reg       <= 1'b0;
      end else if (clk_en) begin
        if (standby) begin
          // R20 standby clears like reset
          ctl_reg       <= dcc_pkg::CTRL_RESET;
          te_seen_reg   <= 1'b0;
          edge_pend_reg <= 1'b0;
          ack_reg       <= 1'b0;
        end else begin
          ctl_reg <= ctl_next;
          if (wr_hit) begin
            te_seen_reg <= 1'b0;
          end else if (rd_acc && hit_ch[i]) begin
            te_seen_reg <= te_seen_reg | te;
          end
          // Edge caught while enabled is kept; consumed by a serviced unit, dropped when the channel is disabled
          if (fall) begin
            edge_pend_reg <= 1'b1;
          end else if (unit_done[i] || !en) begin
            edge_pend_reg <= 1'b0;
          end
          // R7 polarity applied at the pin
          ack_reg <= HAS_EXT & (ack_act ^ ctl_reg[dcc_pkg::BIT_AL]);
        end
        pin_q_reg <= pin_n;
      end
    end

    if (HAS_EXT) begin : g_pin
      assign ext_ack_pin[i] = ack_reg;
    end
  end

endmodule

// ### test/dcc_channel_ctrl_asserts.sv
// Port-level checker for the channel control block
`timescale 1ns/1ns
module dcc_channel_ctrl_asserts #(
  parameter int NCH = dcc_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    standby,
  input wire logic                    clk_en,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic                    pslverr,
  // Sequencer and interrupt side
  input wire logic [NCH-1:0]          unit_done,
  input wire logic [NCH-1:0]          last_unit,
  input wire logic                    nmi_event,
  input wire logic                    addr_error_event,
  input wire logic [NCH-1:0]          xfer_request,
  input wire logic [NCH-1:0]          ch_enabled,
  input dcc_pkg::dcc_mode_t [NCH-1:0] ch_mode,
  input wire logic [NCH-1:0]          transfer_done_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  req_gated_a: assert property ((xfer_request & ~ch_enabled) == '0)
    else $error("request on a disabled channel");
  auto_req_a: assert property (ch_mode[1].auto_req && ch_enabled[1] |-> xfer_request[1])
    else $error("auto request missing");
  nmi_stop_a: assert property (nmi_event |=> ch_enabled == '0)
    else $error("channel live after nmi");
  aerr_stop_a: assert property (addr_error_event |=> ch_enabled == '0)
    else $error("channel live after address error");
  int_single_a: assert property (!ch_mode[2].single_addr && !ch_mode[3].single_addr)
    else $error("single address on internal channel");
  end_stop_a: assert property (unit_done[1] && last_unit[1] && ch_enabled[1]
    |=> !ch_enabled[1] ##1 !xfer_request[1])
    else $error("channel still live after last unit");
  irq_cause_a: assert property ($rose(transfer_done_irq[1]) |->
    $past(unit_done[1] && last_unit[1]) || $past(psel && penable && pwrite))
    else $error("done interrupt without cause");
  standby_clr_a: assert property (standby && clk_en |=> ch_enabled == '0
    && transfer_done_irq == '0)
    else $error("standby left state");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
endmodule
bind dcc_channel_ctrl dcc_channel_ctrl_asserts #(.NCH(NCH)) u_chk (.*);

// ### test/dcc_channel_ctrl_tb.sv
// Self-checking bench for the channel control block
`timescale 1ns/1ns
`define CHK(n,e,g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dcc_channel_ctrl_tb;
  logic pclk = 0, presetn = 0, standby = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, nmi = 0, aerr = 0;
  logic [1:0] go = 0, pin_n, ack;
  logic [8:0] periph = 0;
  logic [3:0] ud = 0, lu = 0, rc = 0, wc = 0, xreq, en, irq;
  dcc_pkg::dcc_mode_t [3:0] mode;
  int errors = 0, total_checks = 0, idx;
  logic [8:0] sel;
  always #20 pclk = ~pclk;
  dcc_ext_peer peer (.pclk(pclk), .presetn(presetn), .go(go), .ext_request_pin_n(pin_n));
  dcc_channel_ctrl dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .standby(standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_request_pin_n(pin_n),
    .ext_ack_pin(ack), .serial0_rx_full_req(periph[0]), .serial0_tx_empty_req(periph[1]),
    .serial1_rx_full_req(periph[2]), .serial1_tx_empty_req(periph[3]),
    .timer_match_req(periph[7:4]), .conversion_done_req(periph[8]), .unit_done(ud),
    .last_unit(lu), .read_cycle(rc), .write_cycle(wc), .nmi_event(nmi),
    .addr_error_event(aerr), .xfer_request(xreq), .ch_enabled(en), .ch_mode(mode),
    .transfer_done_irq(irq));
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
    apb(0, a, 16'h0000);
    `CHK(n, {16'h0000, e}, prdata)
  endtask
  task automatic unit(input logic [3:0] c, input logic l);
    @(posedge pclk);
    ud <= c; lu <= {4{l}} & c;
    @(posedge pclk);
    ud <= 0; lu <= 0;
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rd(dcc_pkg::OFF_CH0_CTRL, 16'h0000, "ch0 reset");
    rd(dcc_pkg::OFF_GLOBAL, 16'h0000, "glb reset");
    rd(8'h14, 16'h0000, "unmapped");
    `CHK("slverr", 1'b1, err)
    apb(1, dcc_pkg::OFF_CH2_CTRL, 16'hffff);
    rd(dcc_pkg::OFF_CH2_CTRL, 16'hff1d, "ch2 mask");
    apb(1, dcc_pkg::OFF_GLOBAL, 16'h0001);
    for (int c = 0; c < 16; c++) begin
      idx = (c == 13) ? 8 : c - 4;
      sel = ((c >= 4 && c <= 11) || c == 13) ? 9'h001 << idx : 9'h000;
      go <= 2'b11;
      apb(1, dcc_pkg::OFF_CH2_CTRL, {4'h0, c[3:0], 8'h00});
      apb(1, dcc_pkg::OFF_CH2_CTRL, {4'h0, c[3:0], 8'h01});
      periph <= sel;
      tick(2);
      `CHK("src hit", (|sel) || (c == 12), xreq[2])
      periph <= ~sel;
      tick(1);
      `CHK("src miss", c == 12, xreq[2])
    end
    periph <= 0;
    go <= 0;
    apb(1, dcc_pkg::OFF_CH2_CTRL, 16'h0000);
    apb(1, dcc_pkg::OFF_CH1_CTRL, 16'h0c05);
    tick(1);
    `CHK("auto", 1'b1, xreq[1])
    unit(4'h2, 1);
    `CHK("irq", 1'b1, irq[1])
    `CHK("halt", 1'b0, xreq[1])
    apb(1, dcc_pkg::OFF_CH1_CTRL, 16'h0c05);
    rd(dcc_pkg::OFF_CH1_CTRL, 16'h0c07, "te unarmed");
    apb(1, dcc_pkg::OFF_CH1_CTRL, 16'h0c07);
    rd(dcc_pkg::OFF_CH1_CTRL, 16'h0c07, "te one");
    apb(1, dcc_pkg::OFF_CH1_CTRL, 16'h0c04);
    rd(dcc_pkg::OFF_CH1_CTRL, 16'h0c04, "te clear");
    for (int k = 0; k < 4; k++) begin
      apb(1, dcc_pkg::OFF_CH0_CTRL, {8'h00, k[1], k[0], 6'h01});
      go <= 2'b01;
      tick(2);
      `CHK("level req", 1'b1, xreq[0])
      `CHK("ack idle", k[0], ack[0])
      @(posedge pclk);
      rc <= 1;
      @(posedge pclk);
      rc <= 0; wc <= 1;
      #1;
      `CHK("ack rd", k[0] ^ ~k[1], ack[0])
      @(posedge pclk);
      wc <= 0;
      #1;
      `CHK("ack wr", k[0] ^ k[1], ack[0])
      go <= 0;
    end
    apb(1, dcc_pkg::OFF_CH0_CTRL, 16'h0218);
    tick(1);
    `CHK("single", 3'b111, {mode[0].single_addr, mode[0].burst, mode[0].word_size})
    apb(1, dcc_pkg::OFF_CH0_CTRL, 16'h0300);
    tick(1);
    // byte size kept for device side
    `CHK("dir", 2'b10, {mode[0].single_addr, mode[0].mem_to_dev})
    `CHK("byte", 1'b0, mode[0].word_size)
    `CHK("ready", 1'b1, pready)
    apb(1, dcc_pkg::OFF_CH0_CTRL, 16'h0021);
    go <= 2'b01;
    tick(3);
    `CHK("edge req", 1'b1, xreq[0])
    unit(4'h1, 0);
    tick(1);
    `CHK("edge once", 1'b0, xreq[0])
    go <= 0;
    @(posedge pclk);
    nmi <= 1;
    @(posedge pclk);
    nmi <= 0;
    #1;
    `CHK("nmi off", 1'b0, en[0])
    rd(dcc_pkg::OFF_GLOBAL, 16'h0003, "nmi flag");
    apb(1, dcc_pkg::OFF_GLOBAL, 16'h0001);
    tick(1);
    `CHK("nmi clr", 1'b1, en[0])
    @(posedge pclk);
    aerr <= 1;
    @(posedge pclk);
    aerr <= 0;
    #1;
    `CHK("ae off", 1'b0, en[0])
    rd(dcc_pkg::OFF_GLOBAL, 16'h0005, "ae flag");
    apb(1, dcc_pkg::OFF_GLOBAL, 16'h0000);
    rd(dcc_pkg::OFF_GLOBAL, 16'h0000, "glb off");
    `CHK("glb abort", 1'b0, en[0])
    @(posedge pclk);
    standby <= 1;
    @(posedge pclk);
    standby <= 0;
    rd(dcc_pkg::OFF_CH0_CTRL, 16'h0000, "standby");
    complete_run();
  end
endmodule

// ### test/dcc_ext_peer.sv
// External peripheral driving the request pins
`timescale 1ns/1ns
module dcc_ext_peer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bench command, and pins
  input  wire logic [1:0] go,
  output logic      [1:0] ext_request_pin_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_request_pin_n <= 2'b11;
    else ext_request_pin_n <= ~go;
  end
endmodule
